// ### rtl/mmt_pkg.sv
package mmt_pkg;
    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [19:0] ADDR_MASK_CFG    = 20'h00080;
    localparam logic [19:0] ADDR_ID_SETUP    = 20'h00084;
    localparam logic [19:0] ADDR_ASSOC       = 20'h00088;
    localparam logic [19:0] ADDR_INFO        = 20'h0008C;
    localparam logic [19:0] ADDR_ID_BASE     = 20'h10300;
    localparam logic [19:0] ADDR_VEC_BASE    = 20'h10320;
    localparam int          TABLE_SPAN_BYTES = 32;

    // ----------------------------------------------------------------
    // table geometry
    // ----------------------------------------------------------------
    localparam int NUM_MASKS = 8;
    localparam int NUM_PORTS = 16;
    localparam int MASK_W    = 3;
    localparam int PORT_W    = 4;

    // ----------------------------------------------------------------
    // mask configuration fields
    // ----------------------------------------------------------------
    localparam int MC_OP_LSB    = 0;
    localparam int MC_OP_MSB    = 7;
    localparam int MC_PORT_LSB  = 8;
    localparam int MC_PORT_MSB  = 15;
    localparam int MC_MASK_LSB  = 16;
    localparam int MC_MASK_MSB  = 31;
    localparam int MC_PRES_BIT  = 0;

    localparam logic [7:0] OP_VERIFY  = 8'h00;
    localparam logic [7:0] OP_ADD     = 8'h10;
    localparam logic [7:0] OP_REMOVE  = 8'h20;
    localparam logic [7:0] OP_CLEAR   = 8'h40;
    localparam logic [7:0] OP_ADD_ALL = 8'h50;

    // ----------------------------------------------------------------
    // set-up and association fields
    // ----------------------------------------------------------------
    localparam int SU_ID_LSB    = 16;
    localparam int SU_ID_MSB    = 31;
    localparam int SU_MASK_LSB  = 0;
    localparam int SU_MASK_MSB  = 15;
    localparam int AS_CMD_LSB   = 5;
    localparam int AS_CMD_MSB   = 6;
    localparam int AS_LARGE_BIT = 7;
    localparam int AS_EXIST_BIT = 4;
    localparam int AS_SRC_LSB   = 8;
    localparam int AS_SRC_MSB   = 15;

    localparam logic [1:0] CMD_REMOVE = 2'b10;
    localparam logic [1:0] CMD_BIND   = 2'b11;

    // ----------------------------------------------------------------
    // direct id register fields
    // ----------------------------------------------------------------
    localparam int ID_GROUP_LSB = 16;
    localparam int ID_GROUP_MSB = 31;
    localparam int ID_LARGE_BIT = 15;
    localparam int ID_VALID_BIT = 14;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        MMT_ACC_IDLE   = 2'b01,
        MMT_ACC_ACCESS = 2'b10
    } mmt_acc_type;
endpackage

// ### rtl/mmt_vector_table.sv
`timescale 1ns/1ps
module mmt_vector_table #(
    parameter int NMASK = mmt_pkg::NUM_MASKS,
    parameter int NPORT = mmt_pkg::NUM_PORTS
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_wr,
    input  wire logic [mmt_pkg::MASK_W-1:0] i_wr_mask,
    input  wire logic [NPORT-1:0]        i_wr_vec,
    input  wire logic [mmt_pkg::MASK_W-1:0] i_rd_mask,
    output logic      [NPORT-1:0]        o_rd_vec,
    output logic      [NMASK*NPORT-1:0]  o_all_vec
);
    logic [NPORT-1:0] vec_r [NMASK];

    // ----------------------------------------------------------------
    // one bit per switch port, one means port gets copies
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            for (int m = 0; m < NMASK; m++)
                vec_r[m] <= '0;
        end
        else if (i_wr)
        begin
            vec_r[i_wr_mask] <= i_wr_vec;
        end
    end

    assign o_rd_vec = vec_r[i_rd_mask];

    always_comb
    begin
        for (int m = 0; m < NMASK; m++)
            o_all_vec[m*NPORT +: NPORT] = vec_r[m];
    end
endmodule // mmt_vector_table

// ### rtl/mmt_group_table.sv
`timescale 1ns/1ps
module mmt_group_table #(
    parameter int NMASK = mmt_pkg::NUM_MASKS
) (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_wr,
    input  wire logic [mmt_pkg::MASK_W-1:0] i_wr_mask,
    input  wire logic [31:0]                i_wr_word,
    input  wire logic [mmt_pkg::MASK_W-1:0] i_rd_mask,
    output logic      [31:0]                o_rd_word
);
    logic [31:0] ent_r [NMASK];

    // ----------------------------------------------------------------
    // latest write to an entry wins
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            for (int m = 0; m < NMASK; m++)
                ent_r[m] <= mmt_pkg::ZERO_WORD;
        end
        else if (i_wr)
        begin
            ent_r[i_wr_mask] <= i_wr_word;
        end
    end

    assign o_rd_word = ent_r[i_rd_mask];
endmodule // mmt_group_table

// ### rtl/mmt_config.sv
`timescale 1ns/1ps
// Contract
// - clear opcode empties the selected mask
// - add opcode sets one named port in the mask
// - add-all opcode sets every port in the mask
// - remove opcode drops one port, even while bound
// - verify write arms query; read echoes mask, port, presence bit
// - absent port reads presence bit zero with fields echoed
// - set-up register holds group id high, mask number low
// - association command 10 unbinds staged id from staged mask
// - remove command ignores exists flag and source port fields
// - eight direct id registers and eight direct vector registers
// - vector entry holds one bit per port 0 to F
// - port above 15 or mask beyond count is ignored
// - association command 11 binds staged id and width to mask
// - latest bind to a mask replaces any earlier binding
module mmt_config #(
    parameter int NMASK = mmt_pkg::NUM_MASKS,
    parameter int NPORT = mmt_pkg::NUM_PORTS
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [19:0]            i_paddr,
    input  wire logic [31:0]            i_pwdata,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    output logic      [NMASK*NPORT-1:0] o_port_vectors
);
    // ----------------------------------------------------------------
    // apb access tracking
    // ----------------------------------------------------------------
    mmt_pkg::mmt_acc_type acc_r;
    logic                 wr_go;
    logic                 rd_go;
    logic [31:0]          rdata_nxt;
    logic [31:0]          rdata_r;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            acc_r <= mmt_pkg::MMT_ACC_IDLE;
        else
        begin
            case (acc_r)
                mmt_pkg::MMT_ACC_IDLE:
                    if (i_psel && !i_penable)
                        acc_r <= mmt_pkg::MMT_ACC_ACCESS;
                mmt_pkg::MMT_ACC_ACCESS:
                    acc_r <= mmt_pkg::MMT_ACC_IDLE;
                default:
                    acc_r <= mmt_pkg::MMT_ACC_IDLE;
            endcase
        end
    end

    // zero wait state: pready high in every access phase
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;
    // a write lands only in the access phase that follows its own setup
    assign wr_go     = i_psel && i_penable && i_pwrite
                       && (acc_r == mmt_pkg::MMT_ACC_ACCESS);
    assign rd_go     = i_psel && !i_penable && !i_pwrite;

    function automatic logic in_table(input logic [19:0] a, input logic [19:0] base);
        in_table = (a >= base) && (a < base + 20'(mmt_pkg::TABLE_SPAN_BYTES))
                   && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [mmt_pkg::MASK_W-1:0] tbl_idx(input logic [19:0] a);
        tbl_idx = a[2 +: mmt_pkg::MASK_W];
    endfunction

    // index range checks shared by commands and queries
    function automatic logic mask_ok(input logic [15:0] m);
        mask_ok = (32'(m) < NMASK);
    endfunction

    function automatic logic port_ok(input logic [7:0] p);
        port_ok = (32'(p) < NPORT);
    endfunction

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic hit_cfg;
    logic hit_setup;
    logic hit_assoc;
    logic hit_info;
    logic hit_id_tbl;
    logic hit_vec_tbl;

    assign hit_cfg     = (i_paddr == mmt_pkg::ADDR_MASK_CFG);
    assign hit_setup   = (i_paddr == mmt_pkg::ADDR_ID_SETUP);
    assign hit_assoc   = (i_paddr == mmt_pkg::ADDR_ASSOC);
    assign hit_info    = (i_paddr == mmt_pkg::ADDR_INFO);
    assign hit_id_tbl  = in_table(i_paddr, mmt_pkg::ADDR_ID_BASE);
    assign hit_vec_tbl = in_table(i_paddr, mmt_pkg::ADDR_VEC_BASE);

    // ----------------------------------------------------------------
    // mask configuration command decode
    // ----------------------------------------------------------------
    localparam int PORT_WL = mmt_pkg::PORT_W;
    logic [7:0]               mc_op;
    logic [7:0]               mc_port;
    logic [15:0]              mc_mask;
    logic                     mc_ok;
    logic                     mc_wr;
    logic [PORT_WL-1:0]       mc_port_idx;
    logic [mmt_pkg::MASK_W-1:0] mc_mask_idx;
    logic [NPORT-1:0]         sel_vec;
    logic [NPORT-1:0]         new_vec;
    logic                     vec_wr;
    logic [mmt_pkg::MASK_W-1:0] vec_wr_mask;
    logic [NPORT-1:0]         vec_wr_val;
    logic [mmt_pkg::MASK_W-1:0] vec_rd_mask;
    logic [NPORT-1:0]         vec_rd_val;

    assign mc_wr       = wr_go && hit_cfg;
    assign mc_op       = i_pwdata[mmt_pkg::MC_OP_MSB:mmt_pkg::MC_OP_LSB];
    assign mc_port     = i_pwdata[mmt_pkg::MC_PORT_MSB:mmt_pkg::MC_PORT_LSB];
    assign mc_mask     = i_pwdata[mmt_pkg::MC_MASK_MSB:mmt_pkg::MC_MASK_LSB];
    assign mc_port_idx = mc_port[PORT_WL-1:0];
    assign mc_mask_idx = mc_mask[mmt_pkg::MASK_W-1:0];
    // out-of-range port or mask changes nothing
    assign mc_ok       = port_ok(mc_port) && mask_ok(mc_mask);

    always_comb
    begin
        new_vec = sel_vec;
        case (mc_op)
            mmt_pkg::OP_CLEAR:   new_vec = '0;
            mmt_pkg::OP_ADD:     new_vec[mc_port_idx] = 1'b1;
            mmt_pkg::OP_ADD_ALL: new_vec = '1;
            mmt_pkg::OP_REMOVE:  new_vec[mc_port_idx] = 1'b0;
            default:             new_vec = sel_vec;
        endcase
    end

    logic mc_changes;
    assign mc_changes = (mc_op == mmt_pkg::OP_CLEAR) || (mc_op == mmt_pkg::OP_ADD)
                     || (mc_op == mmt_pkg::OP_ADD_ALL) || (mc_op == mmt_pkg::OP_REMOVE);

    // direct vector writes
    logic dv_wr;
    assign dv_wr = wr_go && hit_vec_tbl;

    always_comb
    begin
        vec_wr      = 1'b0;
        vec_wr_mask = mc_mask_idx;
        vec_wr_val  = new_vec;
        if (mc_wr && mc_ok && mc_changes)
            vec_wr = 1'b1;
        else if (dv_wr)
        begin
            vec_wr      = 1'b1;
            vec_wr_mask = tbl_idx(i_paddr);
            vec_wr_val  = i_pwdata[NPORT-1:0];
        end
    end

    assign vec_rd_mask = (mc_wr) ? mc_mask_idx : tbl_idx(i_paddr);

    mmt_vector_table #(
        .NMASK (NMASK),
        .NPORT (NPORT)
    ) u_vec (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr      (vec_wr),
        .i_wr_mask (vec_wr_mask),
        .i_wr_vec  (vec_wr_val),
        .i_rd_mask (vec_rd_mask),
        .o_rd_vec  (vec_rd_val),
        .o_all_vec (o_port_vectors)
    );
    assign sel_vec = vec_rd_val;

    // ----------------------------------------------------------------
    // verify query latch
    // ----------------------------------------------------------------
    logic [7:0]  q_port_r;
    logic [15:0] q_mask_r;
    logic        q_arm_r;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            q_port_r <= 8'h00;
            q_mask_r <= 16'h0000;
            q_arm_r  <= 1'b0;
        end
        else if (mc_wr && mc_ok && (mc_op == mmt_pkg::OP_VERIFY))
        begin
            q_port_r <= mc_port;
            q_mask_r <= mc_mask;
            q_arm_r  <= 1'b1;
        end
    end

    logic [NPORT-1:0] q_vec;
    logic             q_present;
    assign q_vec     = o_port_vectors[32'(q_mask_r[mmt_pkg::MASK_W-1:0]) * NPORT +: NPORT];
    // absent port, bad index or unarmed query reads zero
    assign q_present = q_arm_r && port_ok(q_port_r) && mask_ok(q_mask_r)
                       && q_vec[q_port_r[PORT_WL-1:0]];

    // query answer word: mask, port and presence bit
    logic [31:0] q_word;

    always_comb
    begin
        q_word = mmt_pkg::ZERO_WORD;
        q_word[mmt_pkg::MC_MASK_MSB:mmt_pkg::MC_MASK_LSB] = q_mask_r;
        q_word[mmt_pkg::MC_PORT_MSB:mmt_pkg::MC_PORT_LSB] = q_port_r;
        q_word[mmt_pkg::MC_PRES_BIT] = q_present;
    end

    // ----------------------------------------------------------------
    // staged group id and association commands
    // ----------------------------------------------------------------
    logic [31:0] setup_r;
    logic [15:0] su_id;
    logic [15:0] su_mask;
    logic        as_wr;
    logic [1:0]  as_cmd;
    logic        gt_wr;
    logic [mmt_pkg::MASK_W-1:0] gt_mask;
    logic [31:0] gt_word;
    logic [31:0] gt_rd;
    logic [31:0] bind_word;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            setup_r <= mmt_pkg::ZERO_WORD;
        else if (wr_go && hit_setup)
            setup_r <= i_pwdata;
    end

    assign su_id   = setup_r[mmt_pkg::SU_ID_MSB:mmt_pkg::SU_ID_LSB];
    assign su_mask = setup_r[mmt_pkg::SU_MASK_MSB:mmt_pkg::SU_MASK_LSB];
    assign as_wr   = wr_go && hit_assoc;
    assign as_cmd  = i_pwdata[mmt_pkg::AS_CMD_MSB:mmt_pkg::AS_CMD_LSB];

    always_comb
    begin
        bind_word = mmt_pkg::ZERO_WORD;
        bind_word[mmt_pkg::ID_GROUP_MSB:mmt_pkg::ID_GROUP_LSB] = su_id;
        bind_word[mmt_pkg::ID_LARGE_BIT] = i_pwdata[mmt_pkg::AS_LARGE_BIT];
        bind_word[mmt_pkg::ID_VALID_BIT] = 1'b1;
    end

    always_comb
    begin
        gt_wr   = 1'b0;
        gt_mask = su_mask[mmt_pkg::MASK_W-1:0];
        gt_word = bind_word;
        if (as_wr && mask_ok(su_mask))
        begin
            if (as_cmd == mmt_pkg::CMD_BIND)
                gt_wr = 1'b1;
            else if (as_cmd == mmt_pkg::CMD_REMOVE)
            begin
                // exists flag and source port are not looked at here
                gt_wr   = (gt_rd[mmt_pkg::ID_GROUP_MSB:mmt_pkg::ID_GROUP_LSB] == su_id);
                gt_word = mmt_pkg::ZERO_WORD;
            end
        end
        else if (wr_go && hit_id_tbl)
        begin
            gt_wr   = 1'b1;
            gt_mask = tbl_idx(i_paddr);
            gt_word = i_pwdata;
        end
    end

    mmt_group_table #(
        .NMASK (NMASK)
    ) u_grp (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr      (gt_wr),
        .i_wr_mask (gt_mask),
        .i_wr_word (gt_word),
        .i_rd_mask (as_wr ? su_mask[mmt_pkg::MASK_W-1:0] : tbl_idx(i_paddr)),
        .o_rd_word (gt_rd)
    );

    // ----------------------------------------------------------------
    // read data, captured in setup phase
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = mmt_pkg::ZERO_WORD;
        if (hit_cfg)
            rdata_nxt = q_word;
        else if (hit_setup)
            rdata_nxt = setup_r;
        else if (hit_info)
            rdata_nxt = 32'(NMASK);
        else if (hit_id_tbl)
            rdata_nxt = gt_rd;
        else if (hit_vec_tbl)
            rdata_nxt = 32'(vec_rd_val);
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            rdata_r <= mmt_pkg::ZERO_WORD;
        else if (rd_go)
            rdata_r <= rdata_nxt;
    end

    assign o_prdata = rdata_r;
endmodule // mmt_config

// ### tb/mmt_config_checker.sv
`timescale 1ns/1ps
module mmt_config_checker #(
    parameter int NMASK = 8,
    parameter int NPORT = 16
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [19:0]            i_paddr,
    input  wire logic [31:0]            i_pwdata,
    input  wire logic [31:0]            o_prdata,
    input  wire logic                   o_pready,
    input  wire logic                   o_pslverr,
    input  wire logic [NMASK*NPORT-1:0] o_port_vectors
);
    logic             wr_acc;
    logic             cfg_wr;
    logic             ok;
    logic [7:0]       op;
    logic [2:0]       mask_nxt;
    logic [2:0]       mask_r;
    logic [NPORT-1:0] sel;
    logic [NPORT-1:0] old_w;
    logic [NPORT-1:0] bit_w;
    logic [15:0]      qm_r;
    logic [7:0]       qp_r;
    logic             armed_r;
    logic             pres;

    assign wr_acc   = i_psel && i_penable && i_pwrite && o_pready;
    assign cfg_wr   = wr_acc && i_paddr == mmt_pkg::ADDR_MASK_CFG;
    assign ok       = i_pwdata[31:16] < NMASK && i_pwdata[15:8] < NPORT;
    assign op       = i_pwdata[7:0];
    assign mask_nxt = cfg_wr ? i_pwdata[18:16] : i_paddr[4:2];
    assign sel      = o_port_vectors[NPORT*mask_r +: NPORT];
    assign old_w    = o_port_vectors[NPORT*mask_nxt +: NPORT];
    assign bit_w    = NPORT'(1) << i_pwdata[11:8];
    assign pres     = armed_r && o_port_vectors[NPORT*qm_r[2:0] + qp_r[3:0]];

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
        if (i_sys_rst)
            mask_r <= 3'h0;
        else
            mask_r <= mask_nxt;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
        if (i_sys_rst)
        begin
            qm_r    <= 16'h0000;
            qp_r    <= 8'h00;
            armed_r <= 1'h0;
        end
        else if (cfg_wr && ok && op == mmt_pkg::OP_VERIFY)
        begin
            qm_r    <= i_pwdata[31:16];
            qp_r    <= i_pwdata[15:8];
            armed_r <= 1'h1;
        end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    a_clear_mask: assert property (cfg_wr && ok && op == mmt_pkg::OP_CLEAR |=> sel == '0)
        else $error("clear left ports in mask");
    a_add_port: assert property (cfg_wr && ok && op == mmt_pkg::OP_ADD |=>
        sel == ($past(old_w) | $past(bit_w))) else $error("add gave wrong vector");
    a_add_all: assert property (cfg_wr && ok && op == mmt_pkg::OP_ADD_ALL |=> &sel)
        else $error("add all left a port out");
    a_remove_port: assert property (cfg_wr && ok && op == mmt_pkg::OP_REMOVE |=>
        sel == ($past(old_w) & ~$past(bit_w))) else $error("remove gave wrong vector");
    a_verify_echo: assert property (i_psel && !i_penable && !i_pwrite &&
        i_paddr == mmt_pkg::ADDR_MASK_CFG |=> o_prdata == {qm_r, qp_r, 7'h00, $past(pres)})
        else $error("verify read wrong");
    a_bad_field: assert property (cfg_wr && !ok |=> $stable(o_port_vectors))
        else $error("out of range command changed a table");
    a_bad_op: assert property (cfg_wr && !(op inside {8'h00, 8'h10, 8'h20, 8'h40, 8'h50})
        |=> $stable(o_port_vectors)) else $error("unknown opcode changed a table");
    a_direct_vec: assert property (wr_acc && i_paddr[19:5] == mmt_pkg::ADDR_VEC_BASE[19:5]
        |=> sel == $past(i_pwdata[NPORT-1:0])) else $error("direct vector write lost");
    a_ready_clean: assert property (i_psel && i_penable |-> o_pready && !o_pslverr)
        else $error("access phase not answered cleanly");
endmodule // mmt_config_checker

bind mmt_config mmt_config_checker #(.NMASK(NMASK), .NPORT(NPORT)) mmt_config_checker_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_port_vectors(o_port_vectors));

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [19:0] CFG = mmt_pkg::ADDR_MASK_CFG;
    localparam logic [19:0] SU  = mmt_pkg::ADDR_ID_SETUP;
    localparam logic [19:0] AS  = mmt_pkg::ADDR_ASSOC;
    localparam logic [19:0] IDB = mmt_pkg::ADDR_ID_BASE;
    localparam logic [19:0] VB  = mmt_pkg::ADDR_VEC_BASE;
    logic         i_sys_clk = 1'h0;
    logic         i_sys_rst = 1'h1;
    logic         psel = 1'h0;
    logic         pen = 1'h0;
    logic         pwr = 1'h0;
    logic [19:0]  paddr = 20'h00000;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic [31:0]  prdata;
    logic         pready;
    logic [127:0] vecs;
    logic [15:0]  mv [8];
    logic [31:0]  grp [8];
    logic [15:0]  qm, sid, sm;
    logic [7:0]   qp;
    logic         armed;
    logic [31:0]  r, d;
    logic [7:0]   ops [6] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h50, 8'h30};
    logic [31:0]  seq [11] = '{32'h0000_0610, 32'h0000_0710, 32'h0001_0310, 32'h0001_0410,
        32'h0001_0510, 32'h0002_0050, 32'h0001_0420, 32'h0002_0420, 32'h0001_1010,
        32'h0008_0050, 32'h0000_0730};
    int           bad_count = 0;
    int           comparisons = 0;
    int           seed = 19586;

    always #2.5 i_sys_clk = ~i_sys_clk;

    mmt_config mmt_config_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(), .o_port_vectors(vecs));

    // ----------------------------------------------------------------
    // bus cycles, model and compares
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] v);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge i_sys_clk);
        pen <= 1'h1;
        do @(posedge i_sys_clk); while (pready !== 1'h1);
        r = prdata;
    endtask

    task automatic chk_vec();
        logic [127:0] e;
        // idle bus for one edge, then look at the settled vectors
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge i_sys_clk);
        for (int m = 0; m < 8; m++) e[16*m +: 16] = mv[m];
        comparisons++;
        if (vecs !== e)
        begin
            bad_count++;
            $display("ERROR vectors expected %h seen %h", e, vecs);
        end
    endtask

    task automatic rd(input logic [19:0] a);
        logic [31:0] e;
        e = 32'h0000_0000;
        if (a == CFG) e = {qm, qp, 7'h00, armed & mv[qm[2:0]][qp[3:0]]};
        if (a == mmt_pkg::ADDR_INFO) e = 32'h0000_0008;
        if (a[19:5] == IDB[19:5]) e = grp[a[4:2]];
        if (a[19:5] == VB[19:5]) e = {16'h0000, mv[a[4:2]]};
        apb(1'h0, a, 32'h0000_0000);
        comparisons++;
        if (r !== e)
        begin
            bad_count++;
            $display("ERROR read %h expected %h seen %h", a, e, r);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] v);
        logic [2:0] m;
        logic [3:0] p;
        m = v[18:16];
        p = v[11:8];
        apb(1'h1, a, v);
        if (a == CFG && v[31:16] < 8 && v[15:8] < 16)
            case (v[7:0])
                mmt_pkg::OP_ADD:     mv[m] = mv[m] | (16'h0001 << p);
                mmt_pkg::OP_REMOVE:  mv[m] = mv[m] & ~(16'h0001 << p);
                mmt_pkg::OP_CLEAR:   mv[m] = 16'h0000;
                mmt_pkg::OP_ADD_ALL: mv[m] = 16'hFFFF;
                mmt_pkg::OP_VERIFY:  {qm, qp, armed} = {v[31:8], 1'h1};
                default:             ;
            endcase
        if (a == SU) {sid, sm} = v;
        if (a == AS && sm < 8 && v[6:5] == mmt_pkg::CMD_BIND) grp[sm[2:0]] = {sid, v[7], 15'h4000};
        if (a == AS && sm < 8 && v[6:5] == mmt_pkg::CMD_REMOVE && grp[sm[2:0]][31:16] == sid)
            grp[sm[2:0]] = 32'h0000_0000;
        if (a[19:5] == IDB[19:5]) grp[a[4:2]] = v;
        if (a[19:5] == VB[19:5]) mv[a[4:2]] = v[15:0];
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        for (int m = 0; m < 8; m++) {mv[m], grp[m]} = 48'h0;
        {qm, qp, armed, sid, sm} = 57'h0;
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'h0;
        @(posedge i_sys_clk);
        chk_vec();
        rd(CFG);
        rd(mmt_pkg::ADDR_INFO);
        rd(20'h00090);
        for (int m = 0; m < 8; m++) wr(CFG, {16'(m), 16'h0040});
        chk_vec();
        for (int i = 0; i < 11; i++) wr(CFG, seq[i]);
        chk_vec();
        for (int p = 0; p < 8; p++)
        begin
            wr(CFG, {16'h0002, 8'(p), 8'h00});
            rd(CFG);
        end
        wr(CFG, 32'h0002_1100);
        rd(CFG);
        wr(SU, 32'h1234_0000);
        wr(AS, 32'h0000_00E0);
        wr(SU, 32'h0044_0001);
        wr(AS, 32'h0000_0060);
        wr(SU, 32'hFF02_0002);
        wr(AS, 32'h0000_00E0);
        for (int m = 0; m < 3; m++) rd(IDB + 20'(4*m));
        wr(SU, 32'h5678_0000);
        wr(AS, 32'h0000_0060);
        rd(IDB);
        wr(SU, 32'hFF02_0002);
        wr(AS, 32'h0000_00C0);
        rd(IDB + 20'h8);
        wr(AS, 32'h0000_00E0);
        wr(AS, 32'h0000_FFD0);
        rd(IDB + 20'h8);
        wr(SU, 32'h9999_0001);
        wr(AS, 32'h0000_0040);
        rd(IDB + 20'h4);
        for (int m = 0; m < 8; m++)
        begin
            wr(IDB + 20'(4*m), {16'(m * 273), 16'h4000});
            wr(VB + 20'(4*m), $random(seed));
            rd(IDB + 20'(4*m));
            rd(VB + 20'(4*m));
        end
        chk_vec();
        repeat (60)
        begin
            d = $random(seed);
            d[31:19] = 13'h0000;
            d[15:13] = 3'h0;
            d[7:0] = ops[$unsigned($random(seed)) % 6];
            wr(CFG, d);
            chk_vec();
            rd(CFG);
        end
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge i_sys_clk);
        end_of_test();
    end

    initial
    begin
        repeat (5000) @(posedge i_sys_clk);
        bad_count++;
        end_of_test();
    end
endmodule // tb
